// ### verilog/pbd_params.svh
/*
  Offsets, field positions, reset values and timing counts of the
  self-test, delay and tuning register bank.
  Assumes it is included by bare name; definitions only.
*/
`ifndef PBD_PARAMS_SVH
`define PBD_PARAMS_SVH

// register indices; the byte address is four times the index
`define PBD_IDX_PKT_LEN      8'h7B
`define PBD_IDX_GAP_LEN      8'h7C
`define PBD_IDX_CLK_DELAY    8'h86
`define PBD_IDX_RX_EQ        8'h8A
`define PBD_IDX_GAIN_AB      8'hA0
`define PBD_IDX_GAIN_CD      8'hA1
`define PBD_IDX_SWING_AB     8'hA2
`define PBD_IDX_ST_CTRL      8'hF0

// reset values
`define PBD_RST_PKT_LEN      16'h05DC
`define PBD_RST_GAP_LEN      8'h7D
`define PBD_RST_DELAY        4'h7
`define PBD_RST_RX_EQ        16'h0000
`define PBD_RST_SWING_A      5'h10
`define PBD_RST_SWING_B      5'h08

// field positions
`define PBD_DLY_TX_LSB       4
`define PBD_DLY_RX_LSB       0
`define PBD_GAIN_LO_LSB      0
`define PBD_GAIN_HI_LSB      8
`define PBD_SWING_LO_LSB     0
`define PBD_FORCE_LO_BIT     5
`define PBD_SWING_HI_LSB     8
`define PBD_FORCE_HI_BIT     13
`define PBD_CTRL_EN_BIT      0
`define PBD_CTRL_BUSY_BIT    1

// self-test frame shape, in nibbles
`define PBD_PREAMBLE_LAST    4'hC
`define PBD_PREAMBLE_NIB     4'h5
`define PBD_SFD_LO_NIB       4'h5
`define PBD_SFD_HI_NIB       4'hD
`define PBD_GAP_SHIFT        3
`define PBD_LFSR_SEED        8'hA5

// cycles after reset release before straps and trim are captured
`define PBD_BOOT_WAIT        2'h3

// bus answers
`define PBD_RESP_OKAY        2'h0
`define PBD_RESP_SLVERR      2'h2

`endif

// ### verilog/pbd_pkg.sv
/*
  Types of the self-test, delay and tuning register bank.
  Assumes pbd_params.svh is available for the constants.
*/
package pbd_pkg;

  typedef enum logic [4:0] {
    PBD_IDLE = 5'b0_0001,
    PBD_PRE  = 5'b0_0010,
    PBD_SFD  = 5'b0_0100,
    PBD_DATA = 5'b0_1000,
    PBD_GAP  = 5'b1_0000
  } pbd_gen_state_t;

  typedef struct packed {
    logic [3:0] tx;
    logic [3:0] rx;
  } pbd_delay_t;

  typedef struct packed {
    logic [3:0] d;
    logic [3:0] c;
    logic [3:0] b;
    logic [3:0] a;
  } pbd_gain_t;

  typedef struct packed {
    logic [4:0] b;
    logic [4:0] a;
  } pbd_swing_t;

  typedef struct packed {
    logic           aw_have;
    logic [7:0]     aw_idx;
    logic           aw_ok;
    logic           w_have;
    logic [15:0]    w_data;
    logic [1:0]     w_strb;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [15:0]    rdata;
    logic [1:0]     rresp;
    logic [15:0]    pkt_len;
    logic [7:0]     gap_field;
    pbd_delay_t     dly;
    logic [15:0]    eq_word;
    pbd_gain_t      gain;
    pbd_swing_t     sw_val;
    logic           frc_a;
    logic           frc_b;
    pbd_swing_t     drv;
    logic           gen_en;
    logic [1:0]     boot_cnt;
    logic           boot_done;
    logic [5:0]     strap_s1;
    logic [5:0]     strap_s2;
    pbd_gain_t      trim_s1;
    pbd_gain_t      trim_s2;
    pbd_gen_state_t gst;
    logic [3:0]     pre_cnt;
    logic [16:0]    nib_cnt;
    logic [10:0]    gap_cnt;
    logic [7:0]     lfsr;
    logic [1:0][3:0] buf_mem;
    logic [1:0]     buf_cnt;
    logic           buf_rd;
  } pbd_state_t;

endpackage

// ### verilog/pbd_regs.sv
/*
  Self-test packet generator, interface clock delay and line driver
  tuning register bank, reached over AXI4-Lite.
  Assumes one clock (aclk), synchronous active-low reset, strap and
  trim pins that are static but asynchronous, and a nibble sink that
  may stall through its ready.
*/
// Our own choice: the AXI4-Lite slave port.
// Function
// - packets carry exactly the programmed byte count
// - preamble thirteen 0x5 nibbles then 0xD5
// - idle gap between packets, reset 0x7D
// - each gap step adds four bytes
// - transmit delay code in bits 7:4
// - receive delay code in bits 3:0
// - large variant delays reset to 0111
// - small variant delays load from straps
// - clock delay bits 15:8 read zero
// - gain code steps two percent, 1000 neutral
// - gain codes at bits 3:0 and 11:8
// - gain codes reset from trim, reserved zero
// - swing A used only while force A
// - swing B used only while force B
`timescale 1ns/100ps
`include "pbd_params.svh"

module pbd_regs
  import pbd_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // strap and trim pins
  input  wire logic [2:0]  tx_skew_strap,
  input  wire logic [2:0]  rx_skew_strap,
  input  wire pbd_gain_t   gain_trim,
  // internally determined swing
  input  wire pbd_swing_t  internal_swing,
  // analog controls
  output pbd_delay_t       clock_delay,
  output pbd_gain_t        fine_gain,
  output logic [15:0]      rx_equalizer_word,
  output pbd_swing_t       swing_drive,
  // self-test nibble stream
  output logic [3:0]       selftest_nibble,
  output logic             selftest_valid,
  input  wire logic        selftest_ready
);

  pbd_state_t cur;
  pbd_state_t next_st;

  function automatic logic reg_hit(input logic [7:0] idx);
    case (idx)
      `PBD_IDX_PKT_LEN, `PBD_IDX_GAP_LEN, `PBD_IDX_CLK_DELAY, `PBD_IDX_RX_EQ,
      `PBD_IDX_GAIN_AB, `PBD_IDX_GAIN_CD, `PBD_IDX_SWING_AB, `PBD_IDX_ST_CTRL:
        reg_hit = 1'b1;
      default:
        reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [11:0] addr);
    addr_ok = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) && reg_hit(addr[9:2]);
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [15:0] data,
                                         input logic [1:0]  strb);
    wmerge[7:0]  = strb[0] ? data[7:0]  : old[7:0];
    wmerge[15:8] = strb[1] ? data[15:8] : old[15:8];
  endfunction

  logic        room;
  logic        push;
  logic [3:0]  push_nib;
  logic        pop;
  logic        wr_fire;
  logic [15:0] mw;

  assign s_axi_awready = !cur.aw_have && !cur.bvalid;
  assign s_axi_wready  = !cur.w_have && !cur.bvalid;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_bvalid  = cur.bvalid;
  assign s_axi_bresp   = cur.bresp;
  assign s_axi_rvalid  = cur.rvalid;
  assign s_axi_rresp   = cur.rresp;
  assign s_axi_rdata   = {16'h0000, cur.rdata};

  assign clock_delay       = cur.dly;
  assign fine_gain         = cur.gain;
  assign rx_equalizer_word = cur.eq_word;
  assign swing_drive       = cur.drv;

  assign selftest_valid  = (cur.buf_cnt != 2'h0);
  assign selftest_nibble = cur.buf_mem[cur.buf_rd];
  assign pop             = selftest_valid && selftest_ready;
  // a full buffer stalls the generator, so a stalled sink loses nothing
  assign room            = (cur.buf_cnt != 2'h2);

  always_comb
  begin
    next_st  = cur;
    push     = 1'b0;
    push_nib = 4'h0;
    wr_fire  = 1'b0;
    mw       = 16'h0000;

    // pin synchronisers
    next_st.strap_s1 = {tx_skew_strap, rx_skew_strap};
    next_st.strap_s2 = cur.strap_s1;
    next_st.trim_s1  = gain_trim;
    next_st.trim_s2  = cur.trim_s1;

    // one-time capture of straps and trim once the synchronisers are full
    if (!cur.boot_done)
    begin
      if (cur.boot_cnt == `PBD_BOOT_WAIT)
      begin
        next_st.boot_done = 1'b1;
        next_st.gain = cur.trim_s2;
        if (SMALL_PACKAGE)
        begin
          next_st.dly.tx = {1'b0, cur.strap_s2[5:3]};
          next_st.dly.rx = {1'b0, cur.strap_s2[2:0]};
        end
      end
      else
        next_st.boot_cnt = cur.boot_cnt + 2'h1;
    end

    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_have = 1'b1;
      next_st.aw_idx  = s_axi_awaddr[9:2];
      next_st.aw_ok   = addr_ok(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_have = 1'b1;
      next_st.w_data = s_axi_wdata[15:0];
      next_st.w_strb = s_axi_wstrb[1:0];
    end
    if (cur.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    if (cur.aw_have && cur.w_have && !cur.bvalid)
    begin
      wr_fire         = cur.aw_ok;
      next_st.aw_have = 1'b0;
      next_st.w_have  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = cur.aw_ok ? `PBD_RESP_OKAY : `PBD_RESP_SLVERR;
    end

    if (wr_fire)
    begin
      case (cur.aw_idx)
        `PBD_IDX_PKT_LEN: next_st.pkt_len = wmerge(cur.pkt_len, cur.w_data, cur.w_strb);
        `PBD_IDX_GAP_LEN:
        begin
          mw                = wmerge({8'h00, cur.gap_field}, cur.w_data, cur.w_strb);
          next_st.gap_field = mw[7:0];
        end
        `PBD_IDX_CLK_DELAY:
        begin
          mw             = wmerge({8'h00, cur.dly}, cur.w_data, cur.w_strb);
          next_st.dly.tx = mw[`PBD_DLY_TX_LSB +: 4];
          next_st.dly.rx = mw[`PBD_DLY_RX_LSB +: 4];
        end
        `PBD_IDX_RX_EQ:   next_st.eq_word = wmerge(cur.eq_word, cur.w_data, cur.w_strb);
        `PBD_IDX_GAIN_AB:
        begin
          mw             = wmerge({4'h0, cur.gain.b, 4'h0, cur.gain.a}, cur.w_data, cur.w_strb);
          next_st.gain.a = mw[`PBD_GAIN_LO_LSB +: 4];
          next_st.gain.b = mw[`PBD_GAIN_HI_LSB +: 4];
        end
        `PBD_IDX_GAIN_CD:
        begin
          mw             = wmerge({4'h0, cur.gain.d, 4'h0, cur.gain.c}, cur.w_data, cur.w_strb);
          next_st.gain.c = mw[`PBD_GAIN_LO_LSB +: 4];
          next_st.gain.d = mw[`PBD_GAIN_HI_LSB +: 4];
        end
        `PBD_IDX_SWING_AB:
        begin
          mw               = wmerge({2'h0, cur.frc_b, cur.sw_val.b, 2'h0, cur.frc_a, cur.sw_val.a},
                                    cur.w_data, cur.w_strb);
          next_st.sw_val.a = mw[`PBD_SWING_LO_LSB +: 5];
          next_st.frc_a    = mw[`PBD_FORCE_LO_BIT];
          next_st.sw_val.b = mw[`PBD_SWING_HI_LSB +: 5];
          next_st.frc_b    = mw[`PBD_FORCE_HI_BIT];
        end
        `PBD_IDX_ST_CTRL:
        begin
          mw             = wmerge(16'h0000, cur.w_data, cur.w_strb);
          next_st.gen_en = mw[`PBD_CTRL_EN_BIT];
        end
        default: next_st.gen_en = cur.gen_en;
      endcase
    end

    // read channel, answered one cycle after the address is taken
    if (cur.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = addr_ok(s_axi_araddr) ? `PBD_RESP_OKAY : `PBD_RESP_SLVERR;
      case (addr_ok(s_axi_araddr) ? s_axi_araddr[9:2] : 8'h00)
        `PBD_IDX_PKT_LEN:   next_st.rdata = cur.pkt_len;
        `PBD_IDX_GAP_LEN:   next_st.rdata = {8'h00, cur.gap_field};
        `PBD_IDX_CLK_DELAY: next_st.rdata = {8'h00, cur.dly.tx, cur.dly.rx};
        `PBD_IDX_RX_EQ:     next_st.rdata = cur.eq_word;
        `PBD_IDX_GAIN_AB:   next_st.rdata = {4'h0, cur.gain.b, 4'h0, cur.gain.a};
        `PBD_IDX_GAIN_CD:   next_st.rdata = {4'h0, cur.gain.d, 4'h0, cur.gain.c};
        `PBD_IDX_SWING_AB:  next_st.rdata = {2'h0, cur.frc_b, cur.sw_val.b, 2'h0, cur.frc_a, cur.sw_val.a};
        `PBD_IDX_ST_CTRL:   next_st.rdata = {14'h0000, (cur.gst != PBD_IDLE), cur.gen_en};
        default:            next_st.rdata = 16'h0000;
      endcase
    end

    next_st.drv.a = cur.frc_a ? cur.sw_val.a : internal_swing.a;
    next_st.drv.b = cur.frc_b ? cur.sw_val.b : internal_swing.b;
    // internal swing when not forced (both lines above)

    // packet generator; clearing the enable lets the current packet finish
    case (cur.gst)
      PBD_IDLE:
      begin
        if (cur.gen_en)
        begin
          next_st.gst     = PBD_PRE;
          next_st.pre_cnt = 4'h0;
        end
      end
      PBD_PRE:
      begin
        if (room)
        begin
          push            = 1'b1;
          push_nib        = `PBD_PREAMBLE_NIB;
          next_st.pre_cnt = cur.pre_cnt + 4'h1;
          if (cur.pre_cnt == `PBD_PREAMBLE_LAST)
          begin
            next_st.gst     = PBD_SFD;
            next_st.pre_cnt = 4'h0;
          end
        end
      end
      PBD_SFD:
      begin
        if (room)
        begin
          push            = 1'b1;
          push_nib        = (cur.pre_cnt == 4'h0) ? `PBD_SFD_LO_NIB : `PBD_SFD_HI_NIB;
          next_st.pre_cnt = cur.pre_cnt + 4'h1;
          next_st.nib_cnt = 17'h0_0000;
          next_st.gap_cnt = 11'h001;
          if (cur.pre_cnt != 4'h0)
            next_st.gst = (cur.pkt_len == 16'h0000) ? PBD_GAP : PBD_DATA;
        end
      end
      PBD_DATA:
      begin
        if (room)
        begin
          push            = 1'b1;
          push_nib        = cur.nib_cnt[0] ? cur.lfsr[7:4] : cur.lfsr[3:0];
          next_st.nib_cnt = cur.nib_cnt + 17'h0_0001;
          if (cur.nib_cnt[0])
            next_st.lfsr = {cur.lfsr[6:0], cur.lfsr[7] ^ cur.lfsr[5] ^ cur.lfsr[4] ^ cur.lfsr[3]};
          // two nibbles per configured byte, so the last count is 2*len-1
          if (cur.nib_cnt == {cur.pkt_len - 16'h0001, 1'b1})
            next_st.gst = PBD_GAP;
        end
      end
      PBD_GAP:
      begin
        // eight idle nibble slots, four bytes, per step; a zero field still idles one slot
        if (cur.gap_cnt >= {cur.gap_field, 3'b000})
        begin
          // straight into the next preamble, so no extra idle slot creeps in
          next_st.gst     = cur.gen_en ? PBD_PRE : PBD_IDLE;
          next_st.pre_cnt = 4'h0;
        end
        else
          next_st.gap_cnt = cur.gap_cnt + 11'h001;
      end
      default:
        next_st.gst = PBD_IDLE;
    endcase

    // two-entry buffer in front of the sink
    if (push)
      next_st.buf_mem[cur.buf_rd ^ cur.buf_cnt[0]] = push_nib;
    if (pop)
      next_st.buf_rd = ~cur.buf_rd;
    case ({push, pop})
      2'b10:   next_st.buf_cnt = cur.buf_cnt + 2'h1;
      2'b01:   next_st.buf_cnt = cur.buf_cnt - 2'h1;
      default: next_st.buf_cnt = cur.buf_cnt;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur           <= '0;
      cur.pkt_len   <= `PBD_RST_PKT_LEN;
      cur.gap_field <= `PBD_RST_GAP_LEN;
      // 2.00 ns default, replaced by straps in the small variant
      cur.dly.tx    <= `PBD_RST_DELAY;
      cur.dly.rx    <= `PBD_RST_DELAY;
      cur.eq_word   <= `PBD_RST_RX_EQ;
      cur.sw_val.a  <= `PBD_RST_SWING_A;
      cur.sw_val.b  <= `PBD_RST_SWING_B;
      cur.gst       <= PBD_IDLE;
      cur.lfsr      <= `PBD_LFSR_SEED;
    end
    else
    begin
      cur <= next_st;
    end
  end

endmodule

// ### bench/pbd_regs_chk.sv
/*
  Port-level assertions for the tuning register bank.
  Assumes one clock and a synchronous active-low reset; bound below.
*/
`timescale 1ns/100ps

module pbd_regs_chk
  import pbd_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // outputs under watch
  input wire pbd_delay_t  clock_delay,
  input wire logic [3:0]  selftest_nibble,
  input wire logic        selftest_valid,
  input wire logic        selftest_ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
  dly_reset_a: assert property ($rose(aresetn) |-> clock_delay == 8'h77)
    else $error("delay reset value wrong");
  pre_first_a: assert property ($rose(selftest_valid) |-> selftest_nibble == 4'h5)
    else $error("frame does not open with preamble");
  st_hold_a: assert property (selftest_valid && !selftest_ready |=> selftest_valid && $stable(selftest_nibble))
    else $error("stalled nibble lost");
endmodule

bind pbd_regs pbd_regs_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .clock_delay(clock_delay),
  .selftest_nibble(selftest_nibble), .selftest_valid(selftest_valid), .selftest_ready(selftest_ready));

// ### bench/tb_top.sv
/*
  Self-checking bench for the tuning register bank.
  Assumes the large package variant and static strap and trim pins.
*/
`timescale 1ns/100ps
`include "pbd_params.svh"

module tb_top
  import pbd_pkg::*;
;
  logic        aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, nib;
  logic [1:0]  bresp, rresp;
  pbd_gain_t   trim, fine_gain;
  pbd_swing_t  isw, swing_drive;
  pbd_delay_t  clock_delay, small_dly;
  logic [15:0] eq_word;
  logic        svalid, sready, stall, lazy;
  int          bad_count, check_count, cyc;
  logic [3:0]  nq[$];
  int          cq[$];

  pbd_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_skew_strap(3'h3),
    .rx_skew_strap(3'h5), .gain_trim(trim), .internal_swing(isw), .clock_delay(clock_delay),
    .fine_gain(fine_gain), .rx_equalizer_word(eq_word), .swing_drive(swing_drive),
    .selftest_nibble(nib), .selftest_valid(svalid), .selftest_ready(sready));

  // small variant copy with an idle bus; only its strap-loaded delay is watched
  pbd_regs #(.SMALL_PACKAGE(1'b1)) dut_small (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(12'h000),
    .s_axi_awvalid(1'b0), .s_axi_awready(), .s_axi_wdata(32'h0000_0000), .s_axi_wstrb(4'h0),
    .s_axi_wvalid(1'b0), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b0),
    .s_axi_araddr(12'h000), .s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(1'b0), .tx_skew_strap(3'h3), .rx_skew_strap(3'h5), .gain_trim(trim),
    .internal_swing(isw), .clock_delay(small_dly), .fine_gain(), .rx_equalizer_word(), .swing_drive(),
    .selftest_nibble(), .selftest_valid(), .selftest_ready(1'b0));

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // taken nibbles with the cycle they were taken in
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    sready <= !stall || (cyc % 4 != 3);
    if (svalid && sready)
    begin
      nq.push_back(nib);
      cq.push_back(cyc);
    end
  end

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !lazy;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !lazy;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic t_reset();
    logic [7:0]  idx[7] = '{`PBD_IDX_PKT_LEN, `PBD_IDX_GAP_LEN, `PBD_IDX_CLK_DELAY, `PBD_IDX_RX_EQ,
                            `PBD_IDX_GAIN_AB, `PBD_IDX_GAIN_CD, `PBD_IDX_SWING_AB};
    logic [15:0] ex[7] = '{16'h05DC, 16'h007D, 16'h0077, 16'h0000, 16'h0201, 16'h0403, 16'h0810};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 7; i++)
    begin
      rd(ba(idx[i]), d, r);
      chk(d, {16'h0000, ex[i]});
    end
    chk({16'h0000, fine_gain}, 32'h0000_4321);
    chk({24'h0, small_dly}, 32'h0000_0035);
  endtask

  task automatic t_write();
    logic [31:0] d;
    logic [1:0]  r;
    wr(ba(`PBD_IDX_CLK_DELAY), 16'hAB1E, r);
    rd(ba(`PBD_IDX_CLK_DELAY), d, r);
    chk(d, 32'h0000_001E);
    chk({24'h0, clock_delay}, 32'h0000_001E);
    wr(ba(`PBD_IDX_GAIN_AB), 16'hFFFF, r);
    wr(ba(`PBD_IDX_GAIN_CD), 16'h5A3C, r);
    rd(ba(`PBD_IDX_GAIN_AB), d, r);
    chk(d, 32'h0000_0F0F);
    rd(ba(`PBD_IDX_GAIN_CD), d, r);
    chk(d, 32'h0000_0A0C);
    chk({16'h0, fine_gain}, 32'h0000_ACFF);
    wr(ba(`PBD_IDX_RX_EQ), 16'h010F, r);
    chk({30'h0, r}, {30'h0, `PBD_RESP_OKAY});
    rd(ba(`PBD_IDX_RX_EQ), d, r);
    chk({30'h0, r}, {30'h0, `PBD_RESP_OKAY});
    chk(d, 32'h0000_010F);
    chk({16'h0, eq_word}, 32'h0000_010F);
  endtask

  task automatic t_swing();
    logic [31:0] d;
    logic [1:0]  r;
    isw <= {5'h0A, 5'h15};
    repeat (3) @(posedge aclk);
    chk({22'h0, swing_drive}, {22'h0, 5'h0A, 5'h15});
    wr(ba(`PBD_IDX_SWING_AB), 16'hC033, r);
    repeat (2) @(posedge aclk);
    chk({22'h0, swing_drive}, {22'h0, 5'h0A, 5'h13});
    wr(ba(`PBD_IDX_SWING_AB), 16'h2C00, r);
    repeat (2) @(posedge aclk);
    chk({22'h0, swing_drive}, {22'h0, 5'h0C, 5'h15});
    rd(ba(`PBD_IDX_SWING_AB), d, r);
    chk(d, 32'h0000_2C00);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    // late ready on both answers, so each answer must stand meanwhile
    lazy = 1'b1;
    wr(12'h004, 16'h1234, r);
    chk({30'h0, r}, {30'h0, `PBD_RESP_SLVERR});
    rd(12'h004, d, r);
    chk({30'h0, r}, {30'h0, `PBD_RESP_SLVERR});
    chk(d, 32'h0000_0000);
    lazy = 1'b0;
  endtask

  // two frames of two payload bytes; returns cycles between frames
  task automatic run(input logic [7:0] g, input logic s, output int gp);
    logic [31:0] d;
    logic [1:0]  r;
    int          f;
    f = 19;
    stall = s;
    wr(ba(`PBD_IDX_GAP_LEN), {8'h00, g}, r);
    nq.delete();
    cq.delete();
    wr(ba(`PBD_IDX_ST_CTRL), 16'h0001, r);
    while (nq.size() < 2 * f) @(posedge aclk);
    wr(ba(`PBD_IDX_ST_CTRL), 16'h0000, r);
    do rd(ba(`PBD_IDX_ST_CTRL), d, r); while (d[1] !== 1'b0);
    repeat (6) @(posedge aclk);
    chk(nq.size() % f, 0);
    for (int k = 0; k < 2; k++)
      for (int i = 0; i < 15; i++)
        chk({28'h0, nq[k * f + i]}, (i == 14) ? 32'hD : 32'h5);
    gp = cq[f] - cq[f - 1];
  endtask

  task automatic t_gen();
    logic [1:0] r;
    int         g0, g1, g2;
    wr(ba(`PBD_IDX_PKT_LEN), 16'h0002, r);
    // the stalled run gets a longer gap so the enable is cleared before a third frame
    run(8'h04, 1'b1, g0);
    run(8'h01, 1'b0, g1);
    run(8'h02, 1'b0, g2);
    // one field step is four bytes, eight idle nibble slots between frames
    chk(g1, 9);
    chk(g2 - g1, 8);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #1000000;
    bad_count++;
    summarize();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stall, sready, lazy} = '0;
    {awaddr, araddr, wdata, cyc} = '0;
    wstrb = 4'hF;
    trim = 16'h4321;
    isw = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // trim is captured a few edges after release
    repeat (6) @(posedge aclk);
    t_reset();
    t_write();
    t_swing();
    t_unmapped();
    t_gen();
    summarize();
  end
endmodule
